// ===== hw/hblank_map.vh
// Register offsets, field positions, reset values and codes for the horizontal blank generator
`ifndef HBLANK_MAP_VH
`define HBLANK_MAP_VH

// Register offsets (word addresses on the reg_addr and rd_addr register ports)
`define OFS_BLANK_CLOCK_WIDTH 8'h35
`define OFS_BLANK_LEVEL_SELECT 8'h36
`define OFS_BLANK_ALT_MODE 8'h37
`define OFS_BLANK_PATTERN_LENGTH 8'h38
`define OFS_BLANK_REPEAT_COUNT 8'h39
`define OFS_EVEN_TOGGLE_BASE 8'h40
`define OFS_ODD_TOGGLE_BASE 8'h48
`define OFS_PIXEL_COUNT 8'h3f

// Toggle pages: upper five address bits, six slots used per page
`define EVEN_TOGGLE_PAGE 5'h08
`define ODD_TOGGLE_PAGE 5'h09
`define TOGGLE_SLOTS 3'h6

// Field positions
`define WIDTH_FIELD_MSB 6
`define WIDTH_FIELD_LSB 4

// Reset values
`define RST_TOGGLE 13'h1ffd
`define RST_WIDTH 3'h0
`define RST_LEVEL 1'h0
`define RST_MODE 3'h0
`define RST_LENGTH 13'h0000
`define RST_REPEAT 8'h00

// Alternation modes
`define MODE_ALL_EVEN 3'h0
`define MODE_PAIR_ODD 3'h1
`define MODE_PAIR_EVEN 3'h2
`define MODE_TWO_BANKS 3'h3

// Counts
`define NUM_SEQUENCES 4
`define NUM_TOGGLES 6
`define LAST_PIXEL 13'h1fff

`endif

// ===== hw/horizontal_blank_gen.v
// Horizontal blank pattern generator with blank-area H-clock slowdown
// Behaviour
// - Six 13-bit toggle positions per pattern
// - Blank level holds phase one, three, last at width code 0
// - Mode 0 uses six even toggles always
// - Mode 1: toggles 1-2 odd, 3-6 even
// - Mode 2: toggles 1-2 even, 3-6 odd
// - Mode 3: even bank even, odd bank odd
// - Odd bank used for blank only mode 3
// - Modes 4-7 build repeated blank pattern
// - Repeat count 0-255 only modes 4-7
// - Toggle 5 start, toggle 6 end there
// - Pattern length sets repeat period
// - Width code divides H-clock by 2..14
// - Slowdown only inside blank area
// - Alternation works alone or with vertical
// - Blank settings kept per vertical sequence, width code shared
// - Mode field is three bits, eight modes
// - Level high, width code 0: phases 1,3 high, 2,4 low in blank
// - No start polarity; toggles mark edges
// - Width code 0 holds the blank level
`timescale 1ns/1ps
`default_nettype none
`include "hblank_map.vh"

module horizontal_blank_gen (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Register write port
  input wire reg_write,
  input wire [7:0] reg_addr,
  input wire [12:0] reg_wdata,
  input wire [1:0] reg_seq,
  // Register read port
  input wire [7:0] rd_addr,
  output reg [12:0] rd_data,
  // Timing from the line counter
  input wire line_start,
  input wire odd_line,
  input wire [1:0] active_sequence,
  input wire pixel_hclk,
  // Outputs
  output reg horizontal_blank,
  output reg hclk_phase_one,
  output reg hclk_phase_two,
  output reg hclk_phase_three,
  output reg hclk_phase_four,
  output reg hclk_last_stage
);

  // Repeat engine states
  localparam [1:0] RPT_WAIT = 2'h0;
  localparam [1:0] RPT_RUN = 2'h1;
  localparam [1:0] RPT_DONE = 2'h2;

  // Per-sequence register storage and the shared clock width code
  reg [12:0] even_toggle_mem [0:`NUM_SEQUENCES*8-1];
  reg [12:0] odd_toggle_mem [0:`NUM_SEQUENCES*8-1];
  reg [12:0] length_mem [0:`NUM_SEQUENCES-1];
  reg [7:0] repeat_mem [0:`NUM_SEQUENCES-1];
  reg [2:0] mode_mem [0:`NUM_SEQUENCES-1];
  reg level_mem [0:`NUM_SEQUENCES-1];
  reg [2:0] clock_width_reg;

  reg [12:0] pixel_reg;
  reg [12:0] period_reg;
  reg [7:0] reps_done_reg;
  reg [1:0] rpt_state_reg;
  reg [3:0] div_cnt_reg;
  reg slow_clk_reg;
  reg blank_next;
  reg [3:0] div_limit;
  integer i;

  wire [4:0] seq_base = {active_sequence, 3'h0};
  wire [4:0] wr_base = {reg_seq, 3'h0};
  wire [2:0] mode = mode_mem[active_sequence];
  wire level = level_mem[active_sequence];
  wire [12:0] tog_len = length_mem[active_sequence];
  wire [7:0] tog_rep = repeat_mem[active_sequence];
  wire in_repeat_mode = mode[2];
  wire [12:0] rep_begin = even_toggle_mem[seq_base + 5'd4];
  wire [12:0] rep_finish = even_toggle_mem[seq_base + 5'd5];
  wire repeating = (rpt_state_reg == RPT_RUN);
  wire at_begin = ((pixel_reg + 13'h0001) == rep_begin);
  wire at_finish = ((pixel_reg + 13'h0001) == rep_finish);
  wire period_end = ((period_reg + 13'h0001) >= tog_len);

  // Address decode: six slots per bank page, the rest of a page is unmapped
  wire wr_even_slot = (reg_addr[7:3] == `EVEN_TOGGLE_PAGE) && (reg_addr[2:0] < `TOGGLE_SLOTS);
  wire wr_odd_slot = (reg_addr[7:3] == `ODD_TOGGLE_PAGE) && (reg_addr[2:0] < `TOGGLE_SLOTS);
  wire rd_even_slot = (rd_addr[7:3] == `EVEN_TOGGLE_PAGE) && (rd_addr[2:0] < `TOGGLE_SLOTS);
  wire rd_odd_slot = (rd_addr[7:3] == `ODD_TOGGLE_PAGE) && (rd_addr[2:0] < `TOGGLE_SLOTS);

  // Register writes
  always @(posedge core_clk) begin
    if (reset) begin
      clock_width_reg <= `RST_WIDTH;
      for (i = 0; i < `NUM_SEQUENCES; i = i + 1) begin
        mode_mem[i] <= `RST_MODE;
        level_mem[i] <= `RST_LEVEL;
        length_mem[i] <= `RST_LENGTH;
        repeat_mem[i] <= `RST_REPEAT;
      end
      for (i = 0; i < `NUM_SEQUENCES*8; i = i + 1) begin
        even_toggle_mem[i] <= `RST_TOGGLE;
        odd_toggle_mem[i] <= `RST_TOGGLE;
      end
    end else if (reg_write) begin
      case (reg_addr)
        `OFS_BLANK_CLOCK_WIDTH: begin
          clock_width_reg <= reg_wdata[`WIDTH_FIELD_MSB:`WIDTH_FIELD_LSB];
        end
        `OFS_BLANK_LEVEL_SELECT: begin
          level_mem[reg_seq] <= reg_wdata[0];
        end
        `OFS_BLANK_ALT_MODE: begin
          mode_mem[reg_seq] <= reg_wdata[2:0];
        end
        `OFS_BLANK_PATTERN_LENGTH: begin
          length_mem[reg_seq] <= reg_wdata;
        end
        `OFS_BLANK_REPEAT_COUNT: begin
          repeat_mem[reg_seq] <= reg_wdata[7:0];
        end
        default: begin
          // Unmapped addresses fall through and are ignored
          if (wr_even_slot)
            even_toggle_mem[wr_base + {2'h0, reg_addr[2:0]}] <= reg_wdata;
          if (wr_odd_slot)
            odd_toggle_mem[wr_base + {2'h0, reg_addr[2:0]}] <= reg_wdata;
        end
      endcase
    end
  end

  // Register readback of sequence 0 and live state
  always @(posedge core_clk) begin
    if (reset) begin
      rd_data <= 13'h0000;
    end else begin
      case (rd_addr)
        `OFS_BLANK_CLOCK_WIDTH: rd_data <= {6'h00, clock_width_reg, 4'h0};
        `OFS_BLANK_LEVEL_SELECT: rd_data <= {12'h000, level_mem[0]};
        `OFS_BLANK_ALT_MODE: rd_data <= {10'h000, mode_mem[0]};
        `OFS_BLANK_PATTERN_LENGTH: rd_data <= length_mem[0];
        `OFS_BLANK_REPEAT_COUNT: rd_data <= {5'h00, repeat_mem[0]};
        `OFS_PIXEL_COUNT: rd_data <= pixel_reg;
        default: begin
          if (rd_even_slot)
            rd_data <= even_toggle_mem[{2'h0, rd_addr[2:0]}];
          else if (rd_odd_slot)
            rd_data <= odd_toggle_mem[{2'h0, rd_addr[2:0]}];
          else
            rd_data <= 13'h0000;
        end
      endcase
    end
  end

  // Slots allowed to toggle on this line, by alternation mode
  reg [5:0] even_enable;
  reg [5:0] odd_enable;
  always @* begin
    even_enable = 6'h00;
    odd_enable = 6'h00;
    case (mode)
      `MODE_ALL_EVEN: begin
        even_enable = 6'h3f;
      end
      `MODE_PAIR_ODD: begin
        even_enable = odd_line ? 6'h03 : 6'h3c;
      end
      `MODE_PAIR_EVEN: begin
        even_enable = odd_line ? 6'h3c : 6'h03;
      end
      `MODE_TWO_BANKS: begin
        even_enable = odd_line ? 6'h00 : 6'h3f;
        odd_enable = odd_line ? 6'h3f : 6'h00;
      end
      default: begin
        // Repeat modes use their own four slots below
        even_enable = 6'h00;
        odd_enable = 6'h00;
      end
    endcase
  end

  // Repeat modes: slots 1..4 match the position inside the current period
  wire [3:0] repeat_enable = (repeating && in_repeat_mode) ? 4'hf : 4'h0;
  wire [5:0] even_match;
  wire [5:0] odd_match;
  wire [3:0] repeat_match;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_slot
      localparam [4:0] SLOT = g;
      toggle_match #(.WIDTH(13)) i_even_match (
        .position(even_toggle_mem[seq_base + SLOT]),
        .count(pixel_reg),
        .enable(even_enable[g]),
        .match(even_match[g])
      );
      toggle_match #(.WIDTH(13)) i_odd_match (
        .position(odd_toggle_mem[seq_base + SLOT]),
        .count(pixel_reg),
        .enable(odd_enable[g]),
        .match(odd_match[g])
      );
      if (g < 4) begin : g_repeat
        toggle_match #(.WIDTH(13)) i_repeat_match (
          .position(even_toggle_mem[seq_base + SLOT]),
          .count(period_reg),
          .enable(repeat_enable[g]),
          .match(repeat_match[g])
        );
      end
    end
  endgenerate

  // Two slots on one pixel still give one inversion
  wire hit = (|even_match) || (|odd_match) || (|repeat_match);

  // Blank state: no start polarity, starts inactive each line
  always @* begin
    blank_next = horizontal_blank;
    if (line_start)
      blank_next = 1'b0;
    else if (hit)
      blank_next = ~horizontal_blank;
  end

  // Blank output register
  always @(posedge core_clk) begin
    if (reset)
      horizontal_blank <= 1'b0;
    else
      horizontal_blank <= blank_next;
  end

  // Pixel counter; saturates so a long line never wraps onto low toggles
  always @(posedge core_clk) begin
    if (reset)
      pixel_reg <= 13'h0000;
    else if (line_start)
      pixel_reg <= 13'h0000;
    else if (pixel_reg != `LAST_PIXEL)
      pixel_reg <= pixel_reg + 13'h0001;
  end

  // Repeat engine: waits for the start, runs count+1 periods, rests till line end
  always @(posedge core_clk) begin
    if (reset || line_start) begin
      rpt_state_reg <= RPT_WAIT;
      period_reg <= 13'h0000;
      reps_done_reg <= 8'h00;
    end else begin
      case (rpt_state_reg)
        RPT_WAIT: begin
          if (in_repeat_mode && at_begin) begin
            rpt_state_reg <= RPT_RUN;
            period_reg <= 13'h0000;
          end
        end
        RPT_RUN: begin
          if (at_finish) begin
            rpt_state_reg <= RPT_DONE;
          end else if (period_end) begin
            period_reg <= 13'h0000;
            if (reps_done_reg == tog_rep)
              rpt_state_reg <= RPT_DONE;
            else
              reps_done_reg <= reps_done_reg + 8'h01;
          end else begin
            period_reg <= period_reg + 13'h0001;
          end
        end
        RPT_DONE: begin
          // Only the next line start rearms the engine
          rpt_state_reg <= RPT_DONE;
        end
        default: begin
          rpt_state_reg <= RPT_WAIT;
        end
      endcase
    end
  end

  // Half period of the slowed clock less one; code n gives a 2n-cycle period
  always @* begin
    case (clock_width_reg)
      3'h1: div_limit = 4'h0;
      3'h2: div_limit = 4'h1;
      3'h3: div_limit = 4'h2;
      3'h4: div_limit = 4'h3;
      3'h5: div_limit = 4'h4;
      3'h6: div_limit = 4'h5;
      3'h7: div_limit = 4'h6;
      default: div_limit = 4'h0;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      div_cnt_reg <= 4'h0;
      slow_clk_reg <= 1'b0;
    end else if (!blank_next) begin
      div_cnt_reg <= 4'h0;
      slow_clk_reg <= 1'b0;
    end else if (div_cnt_reg >= div_limit) begin
      div_cnt_reg <= 4'h0;
      slow_clk_reg <= ~slow_clk_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
    end
  end

  // Horizontal clock outputs
  reg h_next;
  always @* begin
    if (!blank_next)
      h_next = pixel_hclk;
    else if (clock_width_reg == 3'h0)
      h_next = level;
    else
      h_next = slow_clk_reg;
  end

  always @(posedge core_clk) begin
    if (reset) begin
      hclk_phase_one <= 1'b0;
      hclk_phase_two <= 1'b1;
      hclk_phase_three <= 1'b0;
      hclk_phase_four <= 1'b1;
      hclk_last_stage <= 1'b0;
    end else begin
      hclk_phase_one <= h_next;
      hclk_phase_three <= h_next;
      hclk_last_stage <= h_next;
      hclk_phase_two <= ~h_next;
      hclk_phase_four <= ~h_next;
    end
  end

endmodule // horizontal_blank_gen

// One toggle slot: a stored position against a running count
module toggle_match #(
  parameter WIDTH = 13
) (
  // Compare inputs
  input wire [WIDTH-1:0] position,
  input wire [WIDTH-1:0] count,
  input wire enable,
  // Result
  output wire match
);
  // Purely combinational so a hit lands on the same edge as the count
  assign match = enable && (position == count);
endmodule // toggle_match
`default_nettype wire

// ===== tb/hblank_checker.sv
// Port-level assertions for the horizontal blank generator
`timescale 1ns/1ps
`default_nettype none
module hblank_checker (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Inputs
  input wire logic pixel_hclk,
  input wire logic [7:0] rd_addr,
  // Outputs
  input wire logic [12:0] rd_data,
  input wire logic horizontal_blank,
  input wire logic hclk_phase_one,
  input wire logic hclk_phase_two,
  input wire logic hclk_phase_three,
  input wire logic hclk_phase_four,
  input wire logic hclk_last_stage
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_two_inverse: assert property (hclk_phase_two == !hclk_phase_one)
    else $error("phase two not inverse of one");
  a_four_inverse: assert property (hclk_phase_four == !hclk_phase_three)
    else $error("phase four not inverse of three");
  a_three_tracks: assert property (hclk_phase_three == hclk_phase_one)
    else $error("phase three differs from one");
  a_last_tracks: assert property (hclk_last_stage == hclk_phase_one)
    else $error("last stage differs from phase one");
  a_pixel_outside: assert property (!$past(reset) && !horizontal_blank &&
    !$past(horizontal_blank) |-> hclk_phase_one == $past(pixel_hclk))
    else $error("clock outside blank not at pixel rate");
  a_reset_idle: assert property (disable iff (1'b0) reset |=>
    !horizontal_blank && !hclk_phase_one) else $error("outputs not idle in reset");
  a_reset_read: assert property (disable iff (1'b0) reset |=> rd_data == 13'h0000)
    else $error("read data not cleared in reset");
  a_unmapped_zero: assert property (rd_addr == 8'h3e |=> rd_data == 13'h0000)
    else $error("unmapped read not zero");
endmodule // hblank_checker
bind horizontal_blank_gen hblank_checker i_hblank_checker (
  .core_clk(core_clk), .reset(reset), .pixel_hclk(pixel_hclk), .rd_addr(rd_addr),
  .rd_data(rd_data), .horizontal_blank(horizontal_blank), .hclk_phase_one(hclk_phase_one),
  .hclk_phase_two(hclk_phase_two), .hclk_phase_three(hclk_phase_three),
  .hclk_phase_four(hclk_phase_four), .hclk_last_stage(hclk_last_stage));
`default_nettype wire

// ===== tb/ccd_hreg_model.sv
// Behavioural model of the sensor horizontal shift register
`timescale 1ns/1ps
`default_nettype none
module ccd_hreg_model (
  // Clocks
  input wire logic core_clk,
  input wire logic hclk_phase_one,
  input wire logic hclk_phase_two,
  // Charge moved
  output var logic [15:0] shift_count
);
  logic prev_one = 1'b0;
  initial shift_count = 16'h0000;
  // Only a clean complementary rise moves charge
  always @(posedge core_clk) begin
    prev_one <= hclk_phase_one;
    if (hclk_phase_one && !prev_one && !hclk_phase_two) shift_count <= shift_count + 16'h0001;
  end
endmodule // ccd_hreg_model
`default_nettype wire

// ===== tb/horizontal_blank_gen_tb_top.sv
// Self-checking bench for the horizontal blank generator
`timescale 1ns/1ps
`default_nettype none
`include "hblank_map.vh"
module horizontal_blank_gen_tb_top;
  logic core_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, line_start = 1'b0;
  logic odd_line = 1'b0, pixel_hclk = 1'b0;
  logic [7:0] reg_addr = 8'h00, rd_addr = 8'h00;
  logic [12:0] reg_wdata = 13'h0000;
  logic [1:0] reg_seq = 2'h0, active_sequence = 2'h0;
  wire [12:0] rd_data;
  wire horizontal_blank, hclk_phase_one, hclk_phase_two, hclk_phase_three;
  wire hclk_phase_four, hclk_last_stage;
  wire [15:0] shift_count;
  int err_count = 0, checks_done = 0;
  initial forever #10 core_clk = ~core_clk;
  always @(negedge core_clk) pixel_hclk <= ~pixel_hclk;
  horizontal_blank_gen i_horizontal_blank_gen (.core_clk(core_clk), .reset(reset),
    .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_seq(reg_seq),
    .rd_addr(rd_addr), .rd_data(rd_data), .line_start(line_start), .odd_line(odd_line),
    .active_sequence(active_sequence), .pixel_hclk(pixel_hclk),
    .horizontal_blank(horizontal_blank), .hclk_phase_one(hclk_phase_one),
    .hclk_phase_two(hclk_phase_two), .hclk_phase_three(hclk_phase_three),
    .hclk_phase_four(hclk_phase_four), .hclk_last_stage(hclk_last_stage));
  ccd_hreg_model i_ccd_hreg_model (.core_clk(core_clk), .hclk_phase_one(hclk_phase_one),
    .hclk_phase_two(hclk_phase_two), .shift_count(shift_count));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [12:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge core_clk);
    reg_write = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [12:0] exp);
    rd_addr = a;
    @(negedge core_clk);
    check(rd_data, exp);
  endtask
  // Counts blank edges over one line; spacing and blank-area clocks judged on the way
  task automatic line(input logic odd, input int n, input int gap, input logic lvl, input int wc);
    int cnt, last, lastc, k;
    logic pb, p1;
    cnt = 0;
    last = -1;
    lastc = -1;
    odd_line = odd;
    line_start = 1'b1;
    @(negedge core_clk);
    line_start = 1'b0;
    pb = horizontal_blank;
    p1 = hclk_phase_one;
    for (k = 0; k < 90; k++) begin
      @(negedge core_clk);
      if (horizontal_blank !== pb) begin
        cnt++;
        if (last >= 0) check(k - last, gap);
        last = k;
        lastc = -1;
      end else if (horizontal_blank && wc == 0) begin
        check({hclk_phase_one, hclk_phase_two}, {lvl, !lvl});
      end else if (horizontal_blank && hclk_phase_one !== p1) begin
        if (lastc >= 0) check(k - lastc, wc);
        lastc = k;
      end
      pb = horizontal_blank;
      p1 = hclk_phase_one;
    end
    check(cnt, n);
  endtask
  task automatic t_reset;
    rd(`OFS_EVEN_TOGGLE_BASE, `RST_TOGGLE);
    rd(`OFS_BLANK_ALT_MODE, 13'h0000);
    rd(8'h3e, 13'h0000);
    $display("reset values done");
  endtask
  task automatic t_mode0;
    for (int i = 0; i < 6; i++) wr(`OFS_EVEN_TOGGLE_BASE + 8'(i), 13'(10 * i + 10));
    wr(`OFS_ODD_TOGGLE_BASE, 13'd15);
    wr(`OFS_ODD_TOGGLE_BASE + 8'h01, 13'd35);
    line(1'b1, 6, 10, 1'b0, 0);
    line(1'b0, 6, 10, 1'b0, 0);
    $display("mode zero done");
  endtask
  task automatic t_pairs;
    for (int m = 1; m < 3; m++) begin
      wr(`OFS_BLANK_ALT_MODE, 13'(m));
      line(1'b1, (m == 1) ? 2 : 4, 10, 1'b0, 0);
      line(1'b0, (m == 1) ? 4 : 2, 10, 1'b0, 0);
    end
    $display("pair modes done");
  endtask
  task automatic t_two_banks;
    wr(`OFS_BLANK_ALT_MODE, 13'(`MODE_TWO_BANKS));
    line(1'b1, 2, 20, 1'b0, 0);
    line(1'b0, 6, 10, 1'b0, 0);
    $display("two banks done");
  endtask
  task automatic t_level_width;
    wr(`OFS_BLANK_ALT_MODE, 13'(`MODE_ALL_EVEN));
    wr(`OFS_BLANK_LEVEL_SELECT, 13'h0001);
    line(1'b0, 6, 10, 1'b1, 0);
    for (int c = 1; c < 4; c++) begin
      wr(`OFS_BLANK_CLOCK_WIDTH, 13'(c << 4));
      line(1'b0, 6, 10, 1'b1, c);
    end
    check(shift_count != 16'h0000, 1);
    $display("level and width done");
  endtask
  task automatic t_sequence;
    wr(`OFS_BLANK_CLOCK_WIDTH, 13'h0000);
    active_sequence = 2'h1;
    line(1'b0, 0, 10, 1'b0, 0);
    reg_seq = 2'h1;
    wr(`OFS_EVEN_TOGGLE_BASE, 13'd40);
    wr(`OFS_EVEN_TOGGLE_BASE + 8'h01, 13'd70);
    line(1'b0, 2, 30, 1'b0, 0);
    $display("sequence select done");
  endtask
  task automatic t_repeat;
    wr(`OFS_BLANK_ALT_MODE, 13'h0004);
    wr(`OFS_EVEN_TOGGLE_BASE, 13'd2);
    wr(`OFS_EVEN_TOGGLE_BASE + 8'h01, 13'd7);
    wr(`OFS_EVEN_TOGGLE_BASE + 8'h04, 13'd20);
    wr(`OFS_EVEN_TOGGLE_BASE + 8'h05, 13'd80);
    wr(`OFS_BLANK_PATTERN_LENGTH, 13'd10);
    wr(`OFS_BLANK_REPEAT_COUNT, 13'h0001);
    line(1'b0, 4, 5, 1'b0, 0);
    wr(`OFS_BLANK_REPEAT_COUNT, 13'h0000);
    line(1'b0, 2, 5, 1'b0, 0);
    $display("repeat mode done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(20 * 6000);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (20) @(negedge core_clk);
    reset = 1'b0;
    t_reset();
    t_mode0();
    t_pairs();
    t_two_banks();
    t_level_width();
    t_sequence();
    t_repeat();
    wrap_up();
  end
endmodule // horizontal_blank_gen_tb_top
`default_nettype wire
